// ==== bchp_pkg.sv ====
// Shared constants and types for the byte command handshake port
package bchp_pkg;

  localparam logic [7:0] BCHP_CMD_PRESET_RD  = 8'h60;
  localparam logic [7:0] BCHP_CMD_MODE_RD    = 8'h61;
  localparam logic [7:0] BCHP_CMD_CAL_RD     = 8'h62;
  localparam logic [7:0] BCHP_CMD_WEIGHT_RD  = 8'h63;
  localparam logic [7:0] BCHP_CMD_IO_RD      = 8'h64;
  localparam logic [7:0] BCHP_CMD_RAW_RD     = 8'h65;
  localparam logic [7:0] BCHP_CMD_PRESET_WR  = 8'h70;
  localparam logic [7:0] BCHP_CMD_MODE_WR    = 8'h71;
  localparam logic [7:0] BCHP_CMD_CAL_WR     = 8'h72;
  localparam logic [7:0] BCHP_CMD_IO_WR      = 8'h74;
  localparam logic [7:0] BCHP_CMD_FILTER_WR  = 8'h76;
  localparam logic [7:0] BCHP_CMD_RESTART    = 8'h7F;

  localparam logic [4:0] BCHP_LEN_FLOAT4     = 5'h10;
  localparam logic [4:0] BCHP_LEN_RAW        = 5'h03;
  localparam logic [4:0] BCHP_LEN_WEIGHT     = 5'h04;
  localparam logic [4:0] BCHP_LEN_SHORT      = 5'h01;

  localparam logic [7:0] BCHP_SUCCESS_STATUS_BYTE = 8'h00;
  localparam int         BCHP_STATUS_WR_PEND_BIT  = 0;
  localparam int         BCHP_STATUS_RD_PEND_BIT  = 1;

  localparam int          BCHP_CLK_HZ          = 250_000_000;
  localparam int          BCHP_TIMEOUT_SEC     = 2;
  localparam int unsigned BCHP_TIMEOUT_CYCLES  = BCHP_CLK_HZ * BCHP_TIMEOUT_SEC;

  typedef struct packed {
    logic       sel;
    logic       system_address_line;
    logic       wr_strobe;
    logic       rd_strobe;
    logic [7:0] data;
  } bchp_bus_in_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [4:0] index;
    logic [7:0] data;
  } bchp_wr_byte_type;

  typedef enum logic [2:0] {
    BCHP_ST_IDLE = 3'b001,
    BCHP_ST_SEND = 3'b010,
    BCHP_ST_RECV = 3'b100
  } bchp_state_type;

endpackage

// ==== bchp_timeout.sv ====
// Handshake stall timer for the command port
`timescale 1ns/1ps
module bchp_timeout #(
  parameter int unsigned LIMIT = bchp_pkg::BCHP_TIMEOUT_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic run,
  input  wire logic restart,
  output logic      expired
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] count;

  // Counts only while a transfer waits; any flag edge starts it over
  always_ff @(posedge clk_sys) begin
    if (srst || restart || !run) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + W'(1);
    end
  end

  // The count holds at its end until run drops, so expired is cut to one-cycle pulses on alternate cycles
  always_ff @(posedge clk_sys) begin
    if (srst || restart || !run) begin
      expired <= 1'b0;
    end else begin
      expired <= (count == LAST) && !expired;
    end
  end
endmodule

// ==== bchp_port.sv ====
// Host command port: bus flags, command decode and byte-paced transfers
`timescale 1ns/1ps
module bchp_port
  import bchp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = bchp_pkg::BCHP_TIMEOUT_CYCLES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  input  wire bchp_pkg::bchp_bus_in_type  bus_in,
  output logic [7:0]                      bus_data_out,
  output logic                            bus_data_oe,
  output logic [7:0]                      rd_cmd,
  output logic [4:0]                      rd_index,
  input  wire logic [7:0]                 rd_data,
  output bchp_pkg::bchp_wr_byte_type      wr_byte,
  output logic                            restart_pulse,
  output logic                            cmd_active
);
  import bchp_pkg::*;

  bchp_bus_in_type bus_meta;
  bchp_bus_in_type bus_sync;
  bchp_bus_in_type bus_prev;
  logic            host_write_pending_flag;
  logic            device_read_pending_flag;
  logic [7:0]      in_buf;
  logic [7:0]      out_buf;
  logic [7:0]      port_status_register;
  bchp_state_type  state;
  logic [4:0]      xfer_len;
  logic [7:0]      cmd;
  logic [4:0]      index;
  logic            host_wr_done;
  logic            host_rd_done;
  logic            take_byte;
  logic            load_byte;
  logic            flag_change;
  logic            stall;
  logic            abandon;
  logic            prev_wr_pend;
  logic            prev_rd_pend;
  logic            dec_read;
  logic            dec_write;
  logic [4:0]      dec_len;

  // Pins are asynchronous to clk_sys; only bus_sync and bus_prev are read by logic
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_meta <= '0;
      bus_sync <= '0;
      bus_prev <= '0;
    end else begin
      bus_meta <= bus_in;
      bus_sync <= bus_meta;
      bus_prev <= bus_sync;
    end
  end

  // Strobes act on their trailing edge, when data and address are settled
  assign host_wr_done = bus_prev.wr_strobe && !bus_sync.wr_strobe && bus_prev.sel
                        && !bus_prev.system_address_line;
  assign host_rd_done = bus_prev.rd_strobe && !bus_sync.rd_strobe && bus_prev.sel
                        && !bus_prev.system_address_line;

  assign take_byte = host_write_pending_flag && ((state == BCHP_ST_IDLE) || (state == BCHP_ST_RECV));
  assign load_byte = (state == BCHP_ST_SEND) && !device_read_pending_flag;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_buf <= 8'h00;
    end else if (host_wr_done) begin
      in_buf <= bus_prev.data;
    end
  end

  // A host write landing with the device's take leaves the flag set
  always_ff @(posedge clk_sys) begin
    if (srst || abandon) begin
      host_write_pending_flag <= 1'b0;
    end else if (host_wr_done) begin
      host_write_pending_flag <= 1'b1;
    end else if (take_byte) begin
      host_write_pending_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || abandon) begin
      device_read_pending_flag <= 1'b0;
    end else if (load_byte) begin
      device_read_pending_flag <= 1'b1;
    end else if (host_rd_done) begin
      device_read_pending_flag <= 1'b0;
    end
  end

  // Data sent LSB first; the user side supplies bytes in index order
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_buf <= 8'h00;
    end else if (load_byte) begin
      out_buf <= (index == xfer_len) ? BCHP_SUCCESS_STATUS_BYTE : rd_data;
    end
  end

  always_comb begin
    port_status_register                      = 8'h00;
    port_status_register[BCHP_STATUS_WR_PEND_BIT] = host_write_pending_flag;
    port_status_register[BCHP_STATUS_RD_PEND_BIT] = device_read_pending_flag;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_data_out <= 8'h00;
      bus_data_oe  <= 1'b0;
    end else begin
      bus_data_out <= bus_sync.system_address_line ? port_status_register : out_buf;
      bus_data_oe  <= bus_sync.sel && bus_sync.rd_strobe;
    end
  end

  always_comb begin
    dec_read  = 1'b0;
    dec_write = 1'b0;
    dec_len   = 5'h00;
    case (in_buf)
      BCHP_CMD_PRESET_RD, BCHP_CMD_CAL_RD: begin
        dec_read = 1'b1;
        dec_len  = BCHP_LEN_FLOAT4;
      end
      BCHP_CMD_RAW_RD: begin
        dec_read = 1'b1;
        dec_len  = BCHP_LEN_RAW;
      end
      BCHP_CMD_WEIGHT_RD: begin
        dec_read = 1'b1;
        dec_len  = BCHP_LEN_WEIGHT;
      end
      BCHP_CMD_MODE_RD, BCHP_CMD_IO_RD: begin
        dec_read = 1'b1;
        dec_len  = BCHP_LEN_SHORT;
      end
      BCHP_CMD_PRESET_WR, BCHP_CMD_CAL_WR: begin
        dec_write = 1'b1;
        dec_len   = BCHP_LEN_FLOAT4;
      end
      BCHP_CMD_MODE_WR, BCHP_CMD_IO_WR, BCHP_CMD_FILTER_WR: begin
        dec_write = 1'b1;
        dec_len   = BCHP_LEN_SHORT;
      end
      default: begin
        dec_len = 5'h00;
      end
    endcase
  end

  // Polled every cycle while idle, standing in for the measurement loop
  always_ff @(posedge clk_sys) begin
    if (srst || abandon) begin
      state    <= BCHP_ST_IDLE;
      cmd      <= 8'h00;
      xfer_len <= 5'h00;
      index    <= 5'h00;
    end else begin
      case (state)
        BCHP_ST_IDLE: begin
          if (host_write_pending_flag) begin
            cmd      <= in_buf;
            xfer_len <= dec_len;
            index    <= 5'h00;
            if (dec_read) begin
              state <= BCHP_ST_SEND;
            end else if (dec_write) begin
              state <= BCHP_ST_RECV;
            end
          end
        end
        BCHP_ST_SEND: begin
          if (load_byte) begin
            if (index == xfer_len) begin
              state <= BCHP_ST_IDLE;
            end else begin
              index <= index + 5'h01;
            end
          end
        end
        BCHP_ST_RECV: begin
          if (take_byte) begin
            index <= index + 5'h01;
            if (index + 5'h01 == xfer_len) begin
              state <= BCHP_ST_SEND;
            end
          end
        end
        default: begin
          state <= BCHP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_byte <= '0;
    end else begin
      wr_byte.valid <= (state == BCHP_ST_RECV) && take_byte;
      wr_byte.cmd   <= cmd;
      wr_byte.index <= index;
      wr_byte.data  <= in_buf;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_wr_pend <= 1'b0;
      prev_rd_pend <= 1'b0;
    end else begin
      prev_wr_pend <= host_write_pending_flag;
      prev_rd_pend <= device_read_pending_flag;
    end
  end

  assign flag_change = (prev_wr_pend != host_write_pending_flag)
                       || (prev_rd_pend != device_read_pending_flag);

  bchp_timeout #(
    .LIMIT (TIMEOUT_CYCLES)
  ) u_timeout (
    .clk_sys (clk_sys),
    .srst    (srst),
    .run     (state != BCHP_ST_IDLE),
    .restart (flag_change),
    .expired (stall)
  );

  // The restart code never reaches the transfer states, so it is caught here
  assign abandon = stall
                   || ((state == BCHP_ST_IDLE) && host_write_pending_flag && (in_buf == BCHP_CMD_RESTART));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      restart_pulse <= 1'b0;
    end else begin
      restart_pulse <= abandon;
    end
  end

  assign rd_cmd     = cmd;
  assign rd_index   = index;
  assign cmd_active = (state != BCHP_ST_IDLE);
endmodule

// ==== bchp_port_asserts.sv ====
// Port checker for the byte command handshake port
`timescale 1ns/1ps
module bchp_port_asserts
  import bchp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = bchp_pkg::BCHP_TIMEOUT_CYCLES
) (
  input wire logic                       clk_sys,
  input wire logic                       srst,
  input wire bchp_pkg::bchp_bus_in_type  bus_in,
  input wire logic [7:0]                 bus_data_out,
  input wire logic                       bus_data_oe,
  input wire logic [7:0]                 rd_cmd,
  input wire logic [4:0]                 rd_index,
  input wire logic [7:0]                 rd_data,
  input wire bchp_pkg::bchp_wr_byte_type wr_byte,
  input wire logic                       restart_pulse,
  input wire logic                       cmd_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Cycles of a transfer with no host strobe at all
  logic [31:0] idle_cnt;
  always_ff @(posedge clk_sys) begin
    if (srst || !cmd_active || bus_in.rd_strobe || bus_in.wr_strobe)
      idle_cnt <= '0;
    else
      idle_cnt <= idle_cnt + 1;
  end
  sequence host_rd_rise;
    $rose(bus_in.sel && bus_in.rd_strobe);
  endsequence
  sequence status_view;
    bus_in.system_address_line [*5] ##0 bus_data_oe;
  endsequence
  a_oe_on_read: assert property (host_rd_rise |-> ##[1:4] bus_data_oe)
    else $error("read strobe not answered");
  a_oe_released: assert property ($fell(bus_in.rd_strobe) |-> ##[1:5] !bus_data_oe)
    else $error("data driven after strobe end");
  a_status_upper_zero: assert property (status_view |-> bus_data_out[7:2] == 6'h00)
    else $error("status unused bits set");
  a_wr_valid_pulse: assert property (wr_byte.valid |=> !wr_byte.valid)
    else $error("write byte pulse too long");
  a_wr_cmd_index: assert property (wr_byte.valid |-> wr_byte.cmd[7:4] == 4'h7 && wr_byte.index <= 5'h0F)
    else $error("write byte outside a write command");
  a_restart_single: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse too long");
  a_restart_idle: assert property (restart_pulse |=> !cmd_active)
    else $error("transfer kept after restart");
  a_stall_bound: assert property (cmd_active |-> idle_cnt <= TIMEOUT_CYCLES + 8)
    else $error("stalled transfer not abandoned");
endmodule
bind bchp_port bchp_port_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .bus_in(bus_in), .bus_data_out(bus_data_out),
  .bus_data_oe(bus_data_oe), .rd_cmd(rd_cmd), .rd_index(rd_index), .rd_data(rd_data),
  .wr_byte(wr_byte), .restart_pulse(restart_pulse), .cmd_active(cmd_active));

// ==== bchp_host.sv ====
// Host program model on the I/O bus of the command port
`timescale 1ns/1ps
module bchp_host
  import bchp_pkg::*;
(
  input  wire logic                 clk_sys,
  output bchp_pkg::bchp_bus_in_type bus_in,
  input  wire logic [7:0]           bus_data_out,
  input  wire logic                 bus_data_oe
);
  initial bus_in = '0;
  // One strobe held 6 clk; released data line shows the inverse, not the last value
  task automatic cycle(input logic a, input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    bus_in = '{sel: 1'b1, system_address_line: a, wr_strobe: wr, rd_strobe: !wr, data: d};
    repeat (6) @(posedge clk_sys);
    q = bus_data_oe ? bus_data_out : ~bus_data_out;
    #1;
    bus_in.wr_strobe = 1'b0;
    bus_in.rd_strobe = 1'b0;
    bus_in.data = ~d;
    repeat (5) @(posedge clk_sys);
  endtask
  // Bounded poll stands in for the host's two second limit
  task automatic poll(input int b, input logic want, output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      cycle(1'b1, 1'b0, 8'h00, s);
      ok = (s[b] === want);
    end
  endtask
  task automatic send(input logic [7:0] d, output logic ok);
    logic [7:0] q;
    poll(BCHP_STATUS_WR_PEND_BIT, 1'b0, ok);
    cycle(1'b0, 1'b1, d, q);
  endtask
  task automatic fetch(output logic [7:0] d, output logic ok);
    poll(BCHP_STATUS_RD_PEND_BIT, 1'b1, ok);
    cycle(1'b0, 1'b0, 8'h00, d);
  endtask
endmodule

// ==== bchp_port_tb.sv ====
// Self-checking bench for the byte command handshake port
`timescale 1ns/1ps
module bchp_port_tb;
  import bchp_pkg::*;
  localparam int unsigned TMO = 200;
  logic             clk_sys = 1'b0;
  logic             srst = 1'b1;
  bchp_bus_in_type  bus_in;
  logic [7:0]       bus_data_out, rd_cmd, rd_data, q, salt;
  logic [4:0]       rd_index;
  logic             bus_data_oe, restart_pulse, cmd_active, ok;
  bchp_wr_byte_type wr_byte;
  logic [31:0]      seed = 32'd39270;
  logic [20:0]      wq[$];
  logic [7:0]       wb [16];
  logic [7:0]       rc [6] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
  int               rl [6] = '{16, 1, 16, 4, 1, 3};
  logic [7:0]       wc [5] = '{8'h70, 8'h71, 8'h72, 8'h74, 8'h76};
  int               wl [5] = '{16, 1, 16, 1, 1};
  int               err_total = 0;
  int               total_checks = 0;
  int               restarts = 0;
  always #2 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_byte(input logic [7:0] s, input logic [7:0] c, input logic [4:0] i);
    return s ^ c ^ {i, 3'b101};
  endfunction
  assign rd_data = exp_byte(salt, rd_cmd, rd_index);
  bchp_port #(.TIMEOUT_CYCLES(TMO)) dut (.clk_sys(clk_sys), .srst(srst), .bus_in(bus_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .rd_cmd(rd_cmd), .rd_index(rd_index),
    .rd_data(rd_data), .wr_byte(wr_byte), .restart_pulse(restart_pulse), .cmd_active(cmd_active));
  bchp_host host (.clk_sys(clk_sys), .bus_in(bus_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe));
  always @(posedge clk_sys) begin
    if (wr_byte.valid === 1'b1)
      wq.push_back({wr_byte.cmd, wr_byte.index, wr_byte.data});
    if (restart_pulse === 1'b1)
      restarts++;
  end
  task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_cmd(input logic [7:0] c);
    host.send(c, ok);
    chk(ok, 1, "port busy");
    host.poll(BCHP_STATUS_WR_PEND_BIT, 1'b0, ok);
    chk(ok, 1, "command not taken");
  endtask
  // A stall longer than the timer must abandon the transfer and leave both flags clear
  task automatic stall(input int n0);
    repeat (TMO + 20) @(posedge clk_sys);
    chk(restarts, n0 + 1, "stall restart");
    chk(cmd_active, 0, "stall active");
    host.cycle(1'b1, 1'b0, 8'h00, q);
    chk(q, 8'h00, "status after stall");
  endtask
  initial begin
    salt = 8'h00;
    repeat (6) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    for (int k = 0; k < 6; k++) begin
      salt = seed[7:0];
      seed = xs(seed);
      do_cmd(rc[k]);
      for (int i = 0; i <= rl[k]; i++) begin
        host.fetch(q, ok);
        chk(ok, 1, "byte not offered");
        chk(q, i == rl[k] ? 8'h00 : exp_byte(salt, rc[k], i[4:0]), "read byte");
      end
      host.cycle(1'b1, 1'b0, 8'h00, q);
      chk(q, 8'h00, "status after read");
    end
    for (int k = 0; k < 5; k++) begin
      wq.delete();
      do_cmd(wc[k]);
      for (int i = 0; i < wl[k]; i++) begin
        wb[i] = seed[7:0];
        seed = xs(seed);
        host.send(wb[i], ok);
        chk(ok, 1, "write byte not taken");
      end
      host.fetch(q, ok);
      chk({ok, q}, 9'h100, "write status byte");
      chk(21'(wq.size()), 21'(wl[k]), "write byte count");
      foreach (wq[i]) chk(wq[i], {wc[k], i[4:0], wb[i]}, "written byte");
    end
    do_cmd(8'h55);
    chk(cmd_active, 0, "unknown code");
    host.cycle(1'b1, 1'b0, 8'h00, q);
    chk(q, 8'h00, "status after unknown");
    do_cmd(8'h7F);
    chk(restarts, 1, "restart command");
    do_cmd(8'h65);
    stall(1);
    do_cmd(8'h70);
    host.send(8'h3C, ok);
    stall(2);
    results;
  end
  initial begin
    #200000;
    err_total++;
    results;
  end
endmodule
